// ---- logic/pcsd_pkg.sv ----
`default_nettype none
package pcsd_pkg;

  // ==========================================================================
  // widths
  localparam int PCSD_ADDR_W = 11;
  localparam int PCSD_DATA_W = 16;
  localparam int PCSD_REG_W = 8;
  localparam int PCSD_REG_N = 4;

  // ==========================================================================
  // attribute space decode (address bits 10..3 and 10..9)
  localparam logic [7:0] PCSD_CFG_BLOCK = 8'h40;
  localparam logic [1:0] PCSD_CIS_AREA = 2'h0;

  // ==========================================================================
  // configuration register index (address bits 2..1)
  localparam logic [1:0] PCSD_IDX_OPTION = 2'h0;
  localparam logic [1:0] PCSD_IDX_STATUS = 2'h1;
  localparam logic [1:0] PCSD_IDX_PIN = 2'h2;
  localparam logic [1:0] PCSD_IDX_SOCKET = 2'h3;
  localparam logic [7:0] PCSD_REG_RESET = 8'h00;

  // ==========================================================================
  // lane enables, low active, bit 0 = low byte
  localparam logic [1:0] PCSD_OE_NONE = 2'h3;
  localparam logic [1:0] PCSD_OE_LOW = 2'h2;
  localparam logic [1:0] PCSD_OE_HIGH = 2'h1;
  localparam logic [1:0] PCSD_OE_WORD = 2'h0;

  // ==========================================================================
  // types
  typedef struct packed {
    logic ce_low_n;
    logic ce_high_n;
    logic reg_n;
    logic oe_n;
    logic we_n;
    logic [PCSD_ADDR_W-1:0] addr;
  } pcsd_pins_t;

  localparam pcsd_pins_t PCSD_PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 11'h000};

  typedef enum logic [2:0] {
    PCSD_SP_NONE,
    PCSD_SP_COMMON,
    PCSD_SP_CIS,
    PCSD_SP_CONFIG,
    PCSD_SP_INVALID
  } pcsd_space_t;

  typedef enum logic [1:0] {
    PCSD_LANE_NONE,
    PCSD_LANE_LOW,
    PCSD_LANE_HIGH,
    PCSD_LANE_WORD
  } pcsd_lane_t;

  typedef struct packed {
    pcsd_space_t space;
    pcsd_lane_t lane;
    logic read;
    logic write;
    logic [PCSD_ADDR_W-1:0] addr;
    logic [PCSD_DATA_W-1:0] wdata;
  } pcsd_access_t;

  localparam pcsd_access_t PCSD_ACCESS_IDLE = '{PCSD_SP_NONE, PCSD_LANE_NONE, 1'b0, 1'b0, 11'h000, 16'h0000};

endpackage : pcsd_pkg
`default_nettype wire

// ---- logic/pcsd_decoder.sv ----
`default_nettype none
module pcsd_decoder (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // card pins
  input wire pcsd_pkg::pcsd_pins_t pins,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic [1:0] data_oe_n,
  // storage back end
  output pcsd_pkg::pcsd_access_t access,
  output logic access_start,
  input wire logic [15:0] back_rdata,
  // configuration registers
  output logic [7:0] config_option,
  output logic [7:0] card_config_status,
  output logic [7:0] pin_replacement,
  output logic [7:0] socket_and_copy
);
  import pcsd_pkg::*;

  // ==========================================================================
  // pin synchronisers, three stages, accept when stages two and three agree
  pcsd_pins_t pins_s1, pins_s2, pins_s3, pins_q;
  logic [PCSD_DATA_W-1:0] data_s1, data_s2, data_s3, data_q;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pins_s1 <= PCSD_PINS_IDLE;
      pins_s2 <= PCSD_PINS_IDLE;
      pins_s3 <= PCSD_PINS_IDLE;
      pins_q <= PCSD_PINS_IDLE;
    end else begin
      pins_s1 <= pins;
      pins_s2 <= pins_s1;
      pins_s3 <= pins_s2;
      if (pins_s2 == pins_s3) begin
        pins_q <= pins_s3;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      data_s1 <= '0;
      data_s2 <= '0;
      data_s3 <= '0;
      data_q <= '0;
    end else begin
      data_s1 <= data_in;
      data_s2 <= data_s1;
      data_s3 <= data_s2;
      if (data_s2 == data_s3) begin
        data_q <= data_s3;
      end
    end
  end

  // ==========================================================================
  // strobe decode
  wire ce_lo = ~pins_q.ce_low_n;
  wire ce_hi = ~pins_q.ce_high_n;
  wire attr = ~pins_q.reg_n;
  wire a0 = pins_q.addr[0];
  wire rd = ~pins_q.oe_n & pins_q.we_n;
  wire wr = pins_q.oe_n & ~pins_q.we_n;
  wire strobe = rd | wr;
  wire lo_only = ce_lo & ~ce_hi;
  wire hi_only = ce_hi & ~ce_lo;
  wire both_ce = ce_lo & ce_hi;
  wire cis_area = (pins_q.addr[10:9] == PCSD_CIS_AREA);
  wire cfg_area = (pins_q.addr[10:3] == PCSD_CFG_BLOCK);
  wire [1:0] cfg_idx = pins_q.addr[2:1];

  // ==========================================================================
  // space and lane selection; both enables negated falls through to none
  wire sel_common = ~attr & strobe & (lo_only | hi_only | (both_ce & ~a0));
  wire sel_cis = attr & rd & ce_lo & cis_area & ~a0;
  wire sel_config = attr & strobe & ce_lo & cfg_area & ~a0;
  wire sel_invalid = attr & strobe & ((lo_only & a0) | hi_only)
                   | attr & wr & ce_lo & cis_area;
  wire pcsd_space_t space = sel_invalid ? PCSD_SP_INVALID :
                            sel_common ? PCSD_SP_COMMON :
                            sel_cis ? PCSD_SP_CIS :
                            sel_config ? PCSD_SP_CONFIG : PCSD_SP_NONE;
  // attribute space is byte wide on the low lanes even when both enables are low
  wire pcsd_lane_t lane = (space == PCSD_SP_NONE || space == PCSD_SP_INVALID) ? PCSD_LANE_NONE :
                          (space != PCSD_SP_COMMON) ? PCSD_LANE_LOW :
                          both_ce ? PCSD_LANE_WORD :
                          hi_only ? PCSD_LANE_HIGH : PCSD_LANE_LOW;

  wire valid = (space != PCSD_SP_NONE) && (space != PCSD_SP_INVALID);
  wire pcsd_access_t next_access = valid ? pcsd_access_t'{space, lane, rd, wr, pins_q.addr, data_q} :
                                   PCSD_ACCESS_IDLE;

  // ==========================================================================
  // access start; one commit per strobe, the host negates between cycles
  logic strobe_d;
  wire start = strobe & ~strobe_d;
  wire cfg_write = start & wr & (space == PCSD_SP_CONFIG);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      strobe_d <= 1'b0;
      access <= PCSD_ACCESS_IDLE;
      access_start <= 1'b0;
    end else begin
      strobe_d <= strobe;
      access <= next_access;
      access_start <= start & ((space == PCSD_SP_COMMON) | (space == PCSD_SP_CIS));
    end
  end

  // ==========================================================================
  // configuration registers
  logic [PCSD_REG_W-1:0] cfg_reg [PCSD_REG_N];

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      for (int i = 0; i < PCSD_REG_N; i++) begin
        cfg_reg[i] <= PCSD_REG_RESET;
      end
    end else if (cfg_write) begin
      cfg_reg[cfg_idx] <= data_q[PCSD_REG_W-1:0];
    end
  end

  assign config_option = cfg_reg[PCSD_IDX_OPTION];
  assign card_config_status = cfg_reg[PCSD_IDX_STATUS];
  assign pin_replacement = cfg_reg[PCSD_IDX_PIN];
  assign socket_and_copy = cfg_reg[PCSD_IDX_SOCKET];

  // ==========================================================================
  // read data path, one cycle behind the registered access
  wire [1:0] acc_idx = access.addr[2:1];
  wire [15:0] read_src = (access.space == PCSD_SP_CONFIG) ? {8'h00, cfg_reg[acc_idx]} : back_rdata;
  wire [1:0] next_oe_n = !access.read ? PCSD_OE_NONE :
                         (access.lane == PCSD_LANE_LOW) ? PCSD_OE_LOW :
                         (access.lane == PCSD_LANE_HIGH) ? PCSD_OE_HIGH :
                         (access.lane == PCSD_LANE_WORD) ? PCSD_OE_WORD : PCSD_OE_NONE;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      data_out <= '0;
      data_oe_n <= PCSD_OE_NONE;
    end else begin
      data_out <= read_src;
      data_oe_n <= next_oe_n;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_read_low; ~attr & rd & lo_only; endsequence
  sequence s_read_high; ~attr & rd & hi_only; endsequence
  sequence s_read_word; ~attr & rd & both_ce & ~a0; endsequence
  sequence s_cis_read; attr & rd & lo_only & cis_area & ~a0; endsequence
  // writes are checked at their first cycle only, the back end commits once
  sequence s_write_low; start & wr & ~attr & lo_only; endsequence
  sequence s_write_word; start & wr & ~attr & both_ce & ~a0; endsequence
  sequence s_odd_read; attr & rd & lo_only & a0; endsequence

  a_standby_idle: assert property (~ce_lo & ~ce_hi ##1 1'b1 |=> data_oe_n == PCSD_OE_NONE)
    else $error("lanes driven in standby");
  a_low_byte: assert property (s_read_low |-> ##2 data_oe_n == PCSD_OE_LOW && data_out[7:0] == $past(back_rdata[7:0]))
    else $error("low byte read wrong");
  a_high_byte: assert property (s_read_high |-> ##2 data_oe_n == PCSD_OE_HIGH && data_out[15:8] == $past(back_rdata[15:8]))
    else $error("high byte read wrong");
  a_word_read: assert property (s_read_word |-> ##2 data_oe_n == PCSD_OE_WORD && data_out == $past(back_rdata))
    else $error("word read wrong");
  a_write_lanes: assert property (start & wr & ~attr & hi_only |=> access_start && access.write && access.lane == PCSD_LANE_HIGH)
    else $error("write lane wrong");
  a_cis_read: assert property (s_cis_read |=> access.space == PCSD_SP_CIS ##1 data_oe_n == PCSD_OE_LOW)
    else $error("cis read wrong");
  a_invalid_read: assert property (attr & rd & hi_only |-> ##2 data_oe_n == PCSD_OE_NONE)
    else $error("invalid read drove data");
  a_invalid_write: assert property (attr & wr & ce_lo & (a0 | cis_area) & ~(cfg_area & ~a0) |=> !access_start && $stable(config_option) && $stable(socket_and_copy))
    else $error("invalid write took effect");
  a_config_write: assert property (cfg_write && cfg_idx == PCSD_IDX_PIN |=> pin_replacement == $past(data_q[7:0]))
    else $error("config write lost");
  a_config_read: assert property (attr & rd & ce_lo & cfg_area & ~a0 && cfg_idx == PCSD_IDX_OPTION && !cfg_write
                                  |-> ##2 data_out[7:0] == $past(config_option, 2) && data_oe_n == PCSD_OE_LOW)
    else $error("config read wrong");
  a_low_write: assert property (s_write_low |=> access_start && access.write && access.lane == PCSD_LANE_LOW)
    else $error("low write lane wrong");
  a_word_write: assert property (s_write_word |=> access_start && access.write && access.lane == PCSD_LANE_WORD)
    else $error("word write lane wrong");
  a_standby_quiet: assert property (~ce_lo & ~ce_hi |=> !access_start && access.space == PCSD_SP_NONE)
    else $error("access started in standby");
  a_odd_read_quiet: assert property (s_odd_read |=> !access_start ##1 data_oe_n == PCSD_OE_NONE)
    else $error("odd attribute read took effect");
  a_cis_write_quiet: assert property (attr & wr & lo_only & cis_area & ~a0 |=> !access_start && !access.write)
    else $error("cis write took effect");
  a_high_write_quiet: assert property (attr & wr & hi_only |=> !access_start && $stable(config_option))
    else $error("high only attribute write took effect");
  a_socket_store: assert property (cfg_write && cfg_idx == PCSD_IDX_SOCKET |=> socket_and_copy == $past(data_q[7:0]))
    else $error("socket register write lost");

endmodule : pcsd_decoder
`default_nettype wire

// ---- tb/pcsd_back_model.sv ----
`default_nettype none
// ==========================================================================
// storage back end behind the decoder
module pcsd_back_model (
  // decoded access from the card
  input wire pcsd_pkg::pcsd_access_t access,
  // read data back to the card
  output logic [15:0] back_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import pcsd_pkg::*;
  // idle data toggles, so a stale read can never pass for a match
  // toggles on falling edges only, never racing the sampling edge
  logic flip = 1'b0;
  always #40 flip = ~flip;
  assign back_rdata = access.read ? ({6'h00, access.addr[10:1]} ^ 16'hC3A5) : {16{flip}};
endmodule : pcsd_back_model
`default_nettype wire

// ---- tb/test_pc_card_space_decoder.sv ----
`default_nettype none
// ==========================================================================
// host side bench
module test_pc_card_space_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  import pcsd_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  pcsd_pins_t pins = PCSD_PINS_IDLE;
  logic [15:0] data_in = 16'h0000;
  logic [15:0] data_out;
  logic [15:0] back_rdata;
  logic [1:0] data_oe_n;
  pcsd_access_t access;
  logic access_start;
  logic [7:0] r_opt, r_sts, r_pin, r_sck;
  int miscompares = 0;
  int samples_checked = 0;
  initial begin
    forever #20 clock = ~clock;
  end
  pcsd_decoder dut (.clock(clock), .reset_n(reset_n), .pins(pins), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .access(access), .access_start(access_start), .back_rdata(back_rdata),
    .config_option(r_opt), .card_config_status(r_sts), .pin_replacement(r_pin), .socket_and_copy(r_sck));
  pcsd_back_model back (.access(access), .back_rdata(back_rdata));
  function automatic logic [15:0] pat(input logic [10:0] a);
    return {6'h00, a[10:1]} ^ 16'hC3A5;
  endfunction : pat
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      miscompares++;
    end
  endtask : check
  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // ==========================================================================
  // one strobe cycle; cer = ce_high_n, ce_low_n, reg_n; fixed hold covers sync delay
  task automatic acc(input logic [2:0] cer, input logic rd, input logic [10:0] a, input logic [15:0] wd,
      input logic [1:0] eoe, input logic [15:0] ed, input logic es, input pcsd_lane_t el);
    logic st;
    logic [15:0] m;
    pcsd_access_t sa;
    st = 1'b0;
    sa = PCSD_ACCESS_IDLE;
    m = {{8{~eoe[1]}}, {8{~eoe[0]}}};
    pins = '{cer[1], cer[2], cer[0], ~rd, rd, a};
    data_in = wd;
    repeat (9) begin
      @(negedge clock);
      if (access_start === 1'b1) begin
        st = 1'b1;
        sa = access;
      end
    end
    check({15'h0000, st}, {15'h0000, es});
    check({14'h0000, data_oe_n}, {14'h0000, eoe});
    check(data_out & m, ed & m);
    if (es)
      check({4'h0, sa.write, sa.addr}, {4'h0, ~rd, a});
    if (es && !rd)
      check(sa.wdata, wd);
    if (es && cer[0])
      check({14'h0000, sa.lane}, {14'h0000, el});
    pins = PCSD_PINS_IDLE;
    repeat (6) @(negedge clock);
  endtask : acc
  initial begin
    #100000;
    miscompares++;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    check({r_opt, r_sts, r_pin, r_sck} == 32'h0, 16'h0001);
    repeat (4) @(negedge clock);
    acc(3'b110, 1'b1, 11'h000, 16'h0000, 2'h3, 16'h0000, 1'b0, PCSD_LANE_NONE);
    acc(3'b111, 1'b0, 11'h200, 16'h00AA, 2'h3, 16'h0000, 1'b0, PCSD_LANE_NONE);
    acc(3'b101, 1'b1, 11'h123, 16'h0000, 2'h2, pat(11'h123), 1'b1, PCSD_LANE_LOW);
    acc(3'b011, 1'b1, 11'h0F1, 16'h0000, 2'h1, pat(11'h0F1), 1'b1, PCSD_LANE_HIGH);
    acc(3'b001, 1'b1, 11'h7FE, 16'h0000, 2'h0, pat(11'h7FE), 1'b1, PCSD_LANE_WORD);
    acc(3'b101, 1'b0, 11'h011, 16'h1234, 2'h3, 16'h0000, 1'b1, PCSD_LANE_LOW);
    acc(3'b011, 1'b0, 11'h010, 16'h1234, 2'h3, 16'h0000, 1'b1, PCSD_LANE_HIGH);
    acc(3'b001, 1'b0, 11'h012, 16'h1234, 2'h3, 16'h0000, 1'b1, PCSD_LANE_WORD);
    // host locates the configuration block through the information structure first
    acc(3'b100, 1'b1, 11'h004, 16'h0000, 2'h2, pat(11'h004), 1'b1, PCSD_LANE_NONE);
    for (int i = 0; i < 4; i++)
      acc({~i[0], 2'b00}, 1'b0, 11'h200 | {8'h00, i[1:0], 1'b0}, {8'hFF, 8'h5A + 8'(i)}, 2'h3, 16'h0000, 1'b0,
        PCSD_LANE_NONE);
    for (int i = 0; i < 4; i++)
      acc(3'b100, 1'b1, 11'h200 | {8'h00, i[1:0], 1'b0}, 16'h0000, 2'h2, {8'h00, 8'h5A + 8'(i)}, 1'b0,
        PCSD_LANE_NONE);
    acc(3'b100, 1'b1, 11'h005, 16'h0000, 2'h3, 16'h0000, 1'b0, PCSD_LANE_NONE);
    acc(3'b010, 1'b1, 11'h004, 16'h0000, 2'h3, 16'h0000, 1'b0, PCSD_LANE_NONE);
    acc(3'b100, 1'b0, 11'h201, 16'h0011, 2'h3, 16'h0000, 1'b0, PCSD_LANE_NONE);
    acc(3'b010, 1'b0, 11'h200, 16'h0022, 2'h3, 16'h0000, 1'b0, PCSD_LANE_NONE);
    acc(3'b100, 1'b0, 11'h004, 16'h0033, 2'h3, 16'h0000, 1'b0, PCSD_LANE_NONE);
    check({r_opt, r_sts}, 16'h5A5B);
    check({r_pin, r_sck}, 16'h5C5D);
    tally_and_finish;
  end
endmodule : test_pc_card_space_decoder
`default_nettype wire
